// file: src/stepper_pkg.sv
// Shared constants and types for the stepping motor control-signal block.
// Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus.
package stepper_pkg;

	// Register byte offsets.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_DEVIATION = 8'h08;
	localparam logic [7:0] ADDR_POSITION = 8'h0c;

	// Control register layout and reset value (0 selects dual-pulse mode).
	localparam int CTRL_ONE_PULSE_BIT = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// Bus responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Timing: clock rate and the settle time before positioning completes.
	localparam int CLK_MHZ = 10;
	localparam int END_DELAY_US = 2000;
	localparam int END_DELAY_CYCLES = END_DELAY_US * CLK_MHZ;

	// Geometry in fine units (one fine unit is one step at times ten).
	localparam int BASE_STEPS_PER_REV = 500;
	localparam int RES_MULT = 10;
	localparam int FINE_PER_REV = BASE_STEPS_PER_REV * RES_MULT;
	localparam int TIMING_PER_REV = 50;
	localparam int FINE_PER_TIMING = FINE_PER_REV / TIMING_PER_REV;
	// Window of 1.8 degrees, written in tenths of a degree.
	localparam int WINDOW_DECIDEG = 18;
	localparam int DEV_LIMIT_FINE = WINDOW_DECIDEG * FINE_PER_REV / 3600;

	// Status register contents.
	typedef struct packed {
		logic [23:0] reserved;
		logic res_latched_x10;
		logic res_x10_now;
		logic winding_off;
		logic positioning_done;
		logic fault_system;
		logic fault_data;
		logic fault_overcurrent;
		logic fault_overload;
	} status_t;

	// Positioning-complete settle states.
	typedef enum logic {POS_SETTLING, POS_DONE} pos_state_t;

endpackage : stepper_pkg

// file: src/stepper_pulse_io.sv
// Control-signal logic of a closed-loop stepping motor driver: command
// pulse decode, deviation tracking, alarms and the status outputs.
// Assumes all pins are synchronous to clk_sys, opto-on reads as 1, and
// rotor feedback arrives as one-cycle fine-unit steps on rotor_step_in.
// Behaviour
// [R1] Host waits half a second after power-on before releasing brake.
// [R2] Single-pulse mode: steps on one pin, direction on other, on is clockwise.
// [R3] Dual-pulse mode: clockwise pin steps clockwise, other pin counterclockwise.
// [R4] Dual-pulse mode is the setting after reset.
// [R5] Winding-off input de-energizes the motor windings.
// [R6] Winding-off input clears the deviation counter.
// [R7] Multiply input gives times-ten resolution when switch is at times one.
// [R8] Switch at times ten forces times-ten regardless of multiply input.
// [R9] Alarm-clear input cancels a clearable alarm without power cycling.
// [R10] Over-current, data and system errors clear only on power cycle.
// [R11] Complete output rises 2 ms after last pulse if within 1.8 degrees.
// [R12] Complete output may flash while moving at slow pulse rates.
// [R13] A fault raises alarm, lights indicator, de-energizes motor.
// [R14] Host keeps driver unpowered ten seconds when power cycling.
// [R15] Alarm output conducts when no alarm; other outputs conduct when active.
// [R16] Timing output pulses fifty times per revolution, line driver high.
// [R17] Timing output accuracy is not promised above 500 Hz.
// [R18] Quadrature outputs one pulse per step at power-on resolution.
// [R19] Quadrature channels are a quarter cycle apart.
// [R20] Quadrature outputs lag rotor motion by at most one millisecond.
// [R21] Count a step on entry to opto-on; ignore during winding-off or alarm.
// [R22] Channel A leads for clockwise, channel B leads for counterclockwise.
`timescale 1ns/1ps
module stepper_pulse_io #(
	parameter int END_CYCLES = stepper_pkg::END_DELAY_CYCLES,
	parameter int DEV_WIDTH = 16
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic clockwise_pulse_in,
	input wire logic counterclockwise_pulse_in,
	input wire logic winding_off_in,
	input wire logic res_multiply_in,
	input wire logic res_switch_x10,
	input wire logic fault_clear_in,
	input wire logic fault_overload_in,
	input wire logic fault_overcurrent_in,
	input wire logic fault_data_in,
	input wire logic fault_system_in,
	input wire logic rotor_step_in,
	input wire logic rotor_cw_in,
	output logic motor_energize_out,
	output logic alarm_ok_out,
	output logic alarm_led_out,
	output logic positioning_done_out,
	output logic excitation_timing_oc_out,
	output logic excitation_timing_ld_out,
	output logic quad_a_oc_out,
	output logic quad_b_oc_out,
	output logic quad_a_ld_out,
	output logic quad_b_ld_out
);

	// Fine units moved by one command step at the given resolution.
	function automatic logic [3:0] fine_step(input logic x10);
		fine_step = x10 ? 4'h1 : 4'(stepper_pkg::RES_MULT);
	endfunction : fine_step

	// True for an address that maps to a register.
	function automatic logic addr_known(input logic [7:0] a);
		addr_known = (a == stepper_pkg::ADDR_CTRL) ||
			(a == stepper_pkg::ADDR_STATUS) ||
			(a == stepper_pkg::ADDR_DEVIATION) ||
			(a == stepper_pkg::ADDR_POSITION);
	endfunction : addr_known

	logic one_pulse_mode;
	logic cw_prev, ccw_prev, clr_prev;
	logic f_overload, f_overcurrent, f_data, f_system, alarm_any;
	logic res_latched_x10, init_done;
	logic signed [DEV_WIDTH-1:0] deviation;
	logic [12:0] rev_pos;
	logic [6:0] timing_cnt;
	logic [3:0] quad_sub;
	logic [1:0] quad_phase;
	logic [14:0] quiet_cnt;
	stepper_pkg::pos_state_t pos_state;
	logic aw_held, w_held;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;

	// Resolution, edges and command decode.
	logic res_x10, run_ok, step_pulse_in, rotation_dir_in;
	logic cw_rise, ccw_rise, clr_rise, cmd_step, cmd_cw, in_window;
	logic signed [DEV_WIDTH-1:0] cmd_delta, rotor_delta, abs_dev;
	// [R7] [R8] Times-ten resolution select.
	assign res_x10 = res_switch_x10 | res_multiply_in;
	assign step_pulse_in = clockwise_pulse_in;
	assign rotation_dir_in = counterclockwise_pulse_in;
	assign cw_rise = clockwise_pulse_in & ~cw_prev;
	assign ccw_rise = counterclockwise_pulse_in & ~ccw_prev;
	assign clr_rise = fault_clear_in & ~clr_prev;
	assign alarm_any = f_overload | f_overcurrent | f_data | f_system;
	assign run_ok = ~winding_off_in & ~alarm_any;
	// [R21] Steps on opto-on entry, gated by run state.
	// [R2] [R3] Pulse mode decode; simultaneous dual pulses cancel.
	assign cmd_step = run_ok & (one_pulse_mode ? (step_pulse_in & ~cw_prev) :
		(cw_rise ^ ccw_rise));
	assign cmd_cw = one_pulse_mode ? rotation_dir_in : cw_rise;
	assign cmd_delta = !cmd_step ? '0 : cmd_cw ?
		DEV_WIDTH'(fine_step(res_x10)) : -DEV_WIDTH'(fine_step(res_x10));
	assign rotor_delta = !rotor_step_in ? '0 : rotor_cw_in ?
		DEV_WIDTH'(1) : -DEV_WIDTH'(1);
	assign abs_dev = deviation[DEV_WIDTH-1] ? -deviation : deviation;
	assign in_window = abs_dev <= DEV_WIDTH'(stepper_pkg::DEV_LIMIT_FINE);

	// Input edge history.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cw_prev <= 1'b0;
			ccw_prev <= 1'b0;
			clr_prev <= 1'b0;
		end else if (ce) begin
			cw_prev <= clockwise_pulse_in;
			ccw_prev <= counterclockwise_pulse_in;
			clr_prev <= fault_clear_in;
		end
	end

	// Resolution captured once just after reset release.
	// [R18] Power-on resolution latch.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			init_done <= 1'b0;
			res_latched_x10 <= 1'b0;
		end else if (ce && !init_done) begin
			init_done <= 1'b1;
			res_latched_x10 <= res_x10;
		end
	end

	// Fault flags: overload is clearable, the rest stick until reset.
	// [R9] [R10] Clear reaches overload only; a new fault wins over clear.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			f_overload <= 1'b0;
			f_overcurrent <= 1'b0;
			f_data <= 1'b0;
			f_system <= 1'b0;
		end else if (ce) begin
			if (fault_overload_in)
				f_overload <= 1'b1;
			else if (clr_rise)
				f_overload <= 1'b0;
			if (fault_overcurrent_in)
				f_overcurrent <= 1'b1;
			if (fault_data_in)
				f_data <= 1'b1;
			if (fault_system_in)
				f_system <= 1'b1;
		end
	end

	// Drive and indicator state.
	// [R5] [R13] Windings off on request or alarm.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			motor_energize_out <= 1'b0;
			alarm_led_out <= 1'b0;
		end else if (ce) begin
			motor_energize_out <= run_ok;
			alarm_led_out <= alarm_any;
		end
	end
	// [R15] Alarm line conducts while healthy.
	assign alarm_ok_out = ~alarm_led_out;

	// Deviation between commanded and actual position.
	// [R6] Winding-off clears the deviation.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			deviation <= '0;
		else if (ce) begin
			if (winding_off_in)
				deviation <= '0;
			else
				deviation <= deviation + cmd_delta - rotor_delta;
		end
	end

	// Settle timer and complete output; each pulse restarts the wait, so
	// the output flashes when pulses are spaced beyond the settle time.
	// [R11] [R12] Settle then check window.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			quiet_cnt <= '0;
			pos_state <= stepper_pkg::POS_SETTLING;
			positioning_done_out <= 1'b0;
		end else if (ce) begin
			case (pos_state)
				stepper_pkg::POS_SETTLING: begin
					if (cmd_step || !run_ok)
						quiet_cnt <= '0;
					else if (quiet_cnt != 15'(END_CYCLES))
						quiet_cnt <= quiet_cnt + 15'h1;
					else if (in_window) begin
						pos_state <= stepper_pkg::POS_DONE;
						positioning_done_out <= 1'b1;
					end
				end
				stepper_pkg::POS_DONE: begin
					if (cmd_step || !run_ok || !in_window) begin
						quiet_cnt <= '0;
						pos_state <= stepper_pkg::POS_SETTLING;
						positioning_done_out <= 1'b0;
					end
				end
				default: begin
					pos_state <= stepper_pkg::POS_SETTLING;
					positioning_done_out <= 1'b0;
				end
			endcase
		end
	end

	// Shaft position counters and the timing output; accuracy above the
	// slow pulse range depends on feedback keeping pace.
	// [R16] [R17] Fifty timing marks per turn.
	logic [12:0] next_rev_pos;
	logic [6:0] next_timing_cnt;
	always_comb begin
		next_rev_pos = rev_pos;
		next_timing_cnt = timing_cnt;
		if (rotor_step_in && rotor_cw_in) begin
			next_rev_pos = (rev_pos == 13'(stepper_pkg::FINE_PER_REV - 1)) ?
				13'h0 : rev_pos + 13'h1;
			next_timing_cnt = (timing_cnt ==
				7'(stepper_pkg::FINE_PER_TIMING - 1)) ? 7'h0 : timing_cnt + 7'h1;
		end else if (rotor_step_in) begin
			next_rev_pos = (rev_pos == 13'h0) ?
				13'(stepper_pkg::FINE_PER_REV - 1) : rev_pos - 13'h1;
			next_timing_cnt = (timing_cnt == 7'h0) ?
				7'(stepper_pkg::FINE_PER_TIMING - 1) : timing_cnt - 7'h1;
		end
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rev_pos <= '0;
			timing_cnt <= '0;
			excitation_timing_oc_out <= 1'b0;
		end else if (ce) begin
			rev_pos <= next_rev_pos;
			timing_cnt <= next_timing_cnt;
			excitation_timing_oc_out <= (next_timing_cnt == 7'h0);
		end
	end
	assign excitation_timing_ld_out = excitation_timing_oc_out;

	// Quadrature generator, one cycle behind the rotor step.
	// [R18] [R19] [R20] [R22] Gray sequence per output step.
	logic quad_due;
	logic [3:0] next_quad_sub;
	logic [1:0] next_quad_phase;
	always_comb begin
		next_quad_sub = quad_sub;
		quad_due = 1'b0;
		if (rotor_step_in && rotor_cw_in) begin
			next_quad_sub = (quad_sub == 4'(stepper_pkg::RES_MULT - 1)) ?
				4'h0 : quad_sub + 4'h1;
			quad_due = res_latched_x10 || (next_quad_sub == 4'h0);
		end else if (rotor_step_in) begin
			next_quad_sub = (quad_sub == 4'h0) ?
				4'(stepper_pkg::RES_MULT - 1) : quad_sub - 4'h1;
			quad_due = res_latched_x10 || (quad_sub == 4'h0);
		end
		next_quad_phase = !quad_due ? quad_phase :
			rotor_cw_in ? quad_phase + 2'h1 : quad_phase - 2'h1;
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			quad_sub <= '0;
			quad_phase <= '0;
			quad_a_oc_out <= 1'b0;
			quad_b_oc_out <= 1'b0;
		end else if (ce) begin
			quad_sub <= next_quad_sub;
			quad_phase <= next_quad_phase;
			quad_a_oc_out <= next_quad_phase[1] ^ next_quad_phase[0];
			quad_b_oc_out <= next_quad_phase[1];
		end
	end
	assign quad_a_ld_out = quad_a_oc_out;
	assign quad_b_ld_out = quad_b_oc_out;

	// Bus write side: address and data taken in either order.
	logic aw_got, w_got, do_write;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held & ~s_axi_bvalid;
	assign aw_got = aw_held | (s_axi_awvalid & s_axi_awready);
	assign w_got = w_held | (s_axi_wvalid & s_axi_wready);
	assign do_write = aw_got & w_got & ~s_axi_bvalid;
	assign wr_addr = aw_held ? aw_addr_q : s_axi_awaddr;
	assign wr_data = w_held ? w_data_q : s_axi_wdata;
	assign wr_strb = w_held ? w_strb_q : s_axi_wstrb;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= stepper_pkg::RESP_OKAY;
		end else if (ce) begin
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= addr_known(wr_addr) ? stepper_pkg::RESP_OKAY :
					stepper_pkg::RESP_SLVERR;
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_held <= 1'b1;
					aw_addr_q <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_held <= 1'b1;
					w_data_q <= s_axi_wdata;
					w_strb_q <= s_axi_wstrb;
				end
				if (s_axi_bvalid && s_axi_bready)
					s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Control register.
	// [R4] Dual-pulse mode out of reset.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			one_pulse_mode <= stepper_pkg::CTRL_RESET[stepper_pkg::CTRL_ONE_PULSE_BIT];
		else if (ce && do_write && wr_strb[0] &&
			wr_addr == stepper_pkg::ADDR_CTRL)
			one_pulse_mode <= wr_data[stepper_pkg::CTRL_ONE_PULSE_BIT];
	end

	// Bus read side.
	stepper_pkg::status_t status;
	always_comb begin
		status = '0;
		status.res_latched_x10 = res_latched_x10;
		status.res_x10_now = res_x10;
		status.winding_off = winding_off_in;
		status.positioning_done = positioning_done_out;
		status.fault_system = f_system;
		status.fault_data = f_data;
		status.fault_overcurrent = f_overcurrent;
		status.fault_overload = f_overload;
	end
	assign s_axi_arready = ~s_axi_rvalid;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= stepper_pkg::RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= addr_known(s_axi_araddr) ?
					stepper_pkg::RESP_OKAY : stepper_pkg::RESP_SLVERR;
				case (s_axi_araddr)
					stepper_pkg::ADDR_CTRL: s_axi_rdata <= {31'h0, one_pulse_mode};
					stepper_pkg::ADDR_STATUS: s_axi_rdata <= status;
					stepper_pkg::ADDR_DEVIATION:
						s_axi_rdata <= 32'(signed'(deviation));
					stepper_pkg::ADDR_POSITION: s_axi_rdata <= {19'h0, rev_pos};
					default: s_axi_rdata <= 32'h0000_0000;
				endcase
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// Checks on the behaviour above.
	property p_mode_reset;
		@(posedge clk_sys) $rose(reset_n) |-> !one_pulse_mode;
	endproperty
	a_mode_reset: assert property (p_mode_reset) else $error("mode not dual-pulse after reset"); // [R4]
	property p_one_pulse_dir;
		@(posedge clk_sys) disable iff (!reset_n)
		(cmd_step && one_pulse_mode) |-> cmd_cw == counterclockwise_pulse_in;
	endproperty
	a_one_pulse_dir: assert property (p_one_pulse_dir) else $error("bad direction"); // [R2]
	property p_two_pulse;
		@(posedge clk_sys) disable iff (!reset_n)
		(!one_pulse_mode && run_ok && cw_rise && !ccw_rise) |-> cmd_step && cmd_cw;
	endproperty
	a_two_pulse: assert property (p_two_pulse) else $error("cw pulse lost"); // [R3]
	property p_off_deenergize;
		@(posedge clk_sys) disable iff (!reset_n)
		(ce && (winding_off_in || alarm_any)) |=> !motor_energize_out;
	endproperty
	a_off_deenergize: assert property (p_off_deenergize) else $error("energized"); // [R5]
	property p_off_clears;
		@(posedge clk_sys) disable iff (!reset_n)
		(ce && winding_off_in) |=> deviation == 0;
	endproperty
	a_off_clears: assert property (p_off_clears) else $error("deviation kept"); // [R6]
	property p_res_step;
		@(posedge clk_sys) disable iff (!reset_n)
		cmd_step |-> (cmd_delta == 1 || cmd_delta == -1) == res_x10;
	endproperty
	a_res_step: assert property (p_res_step) else $error("wrong step size"); // [R8]
	property p_fatal_sticks;
		@(posedge clk_sys) disable iff (!reset_n)
		(ce && f_overcurrent && clr_rise) |=> f_overcurrent;
	endproperty
	a_fatal_sticks: assert property (p_fatal_sticks) else $error("fatal cleared"); // [R10]
	property p_clear_works;
		@(posedge clk_sys) disable iff (!reset_n)
		(ce && clr_rise && !fault_overload_in) |=> !f_overload;
	endproperty
	a_clear_works: assert property (p_clear_works) else $error("clear failed"); // [R9]
	property p_done_cause;
		@(posedge clk_sys) disable iff (!reset_n)
		$rose(positioning_done_out) |-> $past(quiet_cnt) == 15'(END_CYCLES)
			&& $past(in_window);
	endproperty
	a_done_cause: assert property (p_done_cause) else $error("early complete"); // [R11]
	property p_alarm_lines;
		@(posedge clk_sys) disable iff (!reset_n)
		(ce && alarm_any) |=> alarm_led_out && !alarm_ok_out;
	endproperty
	a_alarm_lines: assert property (p_alarm_lines) else $error("alarm not shown"); // [R13]
	property p_timing_mark;
		@(posedge clk_sys) disable iff (!reset_n)
		init_done |-> excitation_timing_oc_out == (timing_cnt == 7'h0);
	endproperty
	a_timing_mark: assert property (p_timing_mark) else $error("timing mismatch"); // [R16]
	property p_quad_gray;
		@(posedge clk_sys) disable iff (!reset_n)
		$changed({quad_a_oc_out, quad_b_oc_out}) |->
			$countones({quad_a_oc_out, quad_b_oc_out} ^
			$past({quad_a_oc_out, quad_b_oc_out})) == 1;
	endproperty
	a_quad_gray: assert property (p_quad_gray) else $error("quad jump"); // [R19]
	property p_quad_lag;
		@(posedge clk_sys) disable iff (!reset_n)
		(ce && quad_due) |=> $changed({quad_a_oc_out, quad_b_oc_out});
	endproperty
	a_quad_lag: assert property (p_quad_lag) else $error("quad late"); // [R20]
	property p_ignore_off;
		@(posedge clk_sys) disable iff (!reset_n) !run_ok |-> !cmd_step;
	endproperty
	a_ignore_off: assert property (p_ignore_off) else $error("step while off"); // [R21]
	c_cw_step: cover property (@(posedge clk_sys) cmd_step && cmd_cw);
	c_clear: cover property (@(posedge clk_sys) $fell(f_overload));
	c_done: cover property (@(posedge clk_sys) $rose(positioning_done_out));

endmodule : stepper_pulse_io

// file: testbench/host_ctrl_model.sv
// Far-side model: host pulse source and rotor feedback for the driver.
// Assumes every pin is sampled by the driver on rising clk_sys edges.
`timescale 1ns/1ps
module host_ctrl_model (
	input wire logic clk_sys,
	output logic cw_pin,
	output logic ccw_pin,
	output logic rotor_step,
	output logic rotor_cw
);
	// no supply sequencing
	// No brake or supply pins reach this model, so nothing needs delaying.
	initial begin
		cw_pin = 1'b0;
		ccw_pin = 1'b0;
		rotor_step = 1'b0;
		rotor_cw = 1'b0;
	end
	// pulse with gap
	// One opto-on cycle, then one off cycle so the next edge is seen.
	task automatic cmd(input logic pin);
		@(posedge clk_sys);
		if (pin) ccw_pin <= 1'b1; else cw_pin <= 1'b1;
		@(posedge clk_sys);
		if (pin) ccw_pin <= 1'b0; else cw_pin <= 1'b0;
		@(posedge clk_sys);
	endtask : cmd
	// Holds the direction level used in single-pulse mode.
	task automatic set_dir(input logic v);
		@(posedge clk_sys);
		ccw_pin <= v;
	endtask : set_dir
	// Emits fine-unit rotor steps; direction is inverted between steps.
	task automatic rotor(input int n, input logic dir);
		repeat (n) begin
			@(posedge clk_sys);
			rotor_step <= 1'b1;
			rotor_cw <= dir;
			@(posedge clk_sys);
			rotor_step <= 1'b0;
			rotor_cw <= ~dir;
		end
	endtask : rotor
endmodule : host_ctrl_model

// file: testbench/test_stepper_pulse_io.sv
// Self-checking bench for stepper_pulse_io over AXI4-Lite and pins.
// Assumes the far side is host_ctrl_model and a 100 ns clock.
`timescale 1ns/1ps
module test_stepper_pulse_io;
	localparam int ENDC = 20;
	logic clk_sys, reset_n, awv, awr, wv, wr_rdy, bv, brdy, arv, arr;
	logic rv, rrdy, mul, sw, woff, clr, ovl, oc, dat, sys, en, aok, led;
	logic done, t_oc, t_ld, qa, qb, qa_ld, qb_ld, cwp, ccwp, rs, rcw;
	logic ce;
	logic [3:0] ws;
	logic [7:0] awa, ara;
	logic [31:0] wd, rdat, d;
	logic [1:0] br, rr, r, q;
	int err_count, checks;
	stepper_pulse_io #(.END_CYCLES(ENDC)) u_stepper_pulse_io (
		.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(rrdy),
		.clockwise_pulse_in(cwp), .counterclockwise_pulse_in(ccwp),
		.winding_off_in(woff), .res_multiply_in(mul),
		.res_switch_x10(sw), .fault_clear_in(clr),
		.fault_overload_in(ovl), .fault_overcurrent_in(oc),
		.fault_data_in(dat), .fault_system_in(sys),
		.rotor_step_in(rs), .rotor_cw_in(rcw),
		.motor_energize_out(en), .alarm_ok_out(aok), .alarm_led_out(led),
		.positioning_done_out(done), .excitation_timing_oc_out(t_oc),
		.excitation_timing_ld_out(t_ld), .quad_a_oc_out(qa),
		.quad_b_oc_out(qb), .quad_a_ld_out(qa_ld), .quad_b_ld_out(qb_ld));
	host_ctrl_model u_host_ctrl_model (.clk_sys(clk_sys), .cw_pin(cwp),
		.ccw_pin(ccwp), .rotor_step(rs), .rotor_cw(rcw));
	// Free-running system clock.
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop;
		$display("Checks %0d, errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	// Compares one value and counts it.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Bus write; each channel is released at the edge that takes it.
	task automatic bwr(input logic [7:0] a, input logic [31:0] v);
		logic ah, wh;
		ah = 1'b0;
		wh = 1'b0;
		@(posedge clk_sys);
		awa <= a;
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		while (!(ah && wh)) begin
			@(posedge clk_sys);
			if (!ah && awr) begin
				ah = 1'b1;
				awv <= 1'b0;
			end
			if (!wh && wr_rdy) begin
				wh = 1'b1;
				wv <= 1'b0;
			end
		end
		do @(posedge clk_sys); while (bv !== 1'b1);
		r = br;
		brdy <= 1'b0;
	endtask : bwr
	// Bus read into d and r, both taken at the handshake edge.
	task automatic brd(input logic [7:0] a);
		@(posedge clk_sys);
		ara <= a;
		arv <= 1'b1;
		rrdy <= 1'b1;
		do @(posedge clk_sys); while (arr !== 1'b1);
		arv <= 1'b0;
		do @(posedge clk_sys); while (rv !== 1'b1);
		d = rdat;
		r = rr;
		rrdy <= 1'b0;
	endtask : brd
	// Reads a register and compares its data.
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		brd(a);
		chk(d, exp);
	endtask : rchk
	// Holds reset for twelve cycles, then lets two edges pass so the
	// first registered outputs have settled.
	task automatic rst;
		reset_n <= 1'b0;
		repeat (12) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
	endtask : rst
	// Pulses the pins {overload, overcurrent, data, system, clear} given
	// by sel for one cycle and lets outputs settle.
	task automatic pulse(input logic [4:0] sel);
		{ovl, oc, dat, sys, clr} <= sel;
		@(posedge clk_sys);
		{ovl, oc, dat, sys, clr} <= 5'h00;
		repeat (3) @(posedge clk_sys);
	endtask : pulse
	// Ends a hung run well past the expected length.
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_count++;
		report_and_stop;
	end
	// Main sequence.
	initial begin
		{reset_n, awv, wv, brdy, arv, rrdy, mul, sw, woff, clr} = '0;
		{ovl, oc, dat, sys, awa, ara, wd} = '0;
		ce = 1'b1;
		ws = 4'hf;
		err_count = 0;
		checks = 0;
		rst;
		chk({aok, led, en}, 3'b101);
		rchk(stepper_pkg::ADDR_CTRL, stepper_pkg::CTRL_RESET);
		ws <= 4'he;
		bwr(stepper_pkg::ADDR_CTRL, 32'h0000_0001);
		ws <= 4'hf;
		rchk(stepper_pkg::ADDR_CTRL, 32'h0000_0000);
		brd(8'h10);
		chk(r, stepper_pkg::RESP_SLVERR);
		bwr(8'h14, 32'h0000_0001);
		chk(r, stepper_pkg::RESP_SLVERR);
		u_host_ctrl_model.cmd(1'b0);
		rchk(stepper_pkg::ADDR_DEVIATION, 32'h0000_000a);
		u_host_ctrl_model.cmd(1'b1);
		u_host_ctrl_model.cmd(1'b1);
		rchk(stepper_pkg::ADDR_DEVIATION, 32'hffff_fff6);
		mul <= 1'b1;
		u_host_ctrl_model.cmd(1'b0);
		rchk(stepper_pkg::ADDR_DEVIATION, 32'hffff_fff7);
		mul <= 1'b0;
		sw <= 1'b1;
		u_host_ctrl_model.cmd(1'b0);
		rchk(stepper_pkg::ADDR_DEVIATION, 32'hffff_fff8);
		sw <= 1'b0;
		woff <= 1'b1;
		u_host_ctrl_model.cmd(1'b0);
		rchk(stepper_pkg::ADDR_DEVIATION, 32'h0000_0000);
		chk(en, 1'b0);
		woff <= 1'b0;
		bwr(stepper_pkg::ADDR_CTRL, 32'h0000_0001);
		u_host_ctrl_model.set_dir(1'b1);
		u_host_ctrl_model.cmd(1'b0);
		rchk(stepper_pkg::ADDR_DEVIATION, 32'h0000_000a);
		u_host_ctrl_model.set_dir(1'b0);
		u_host_ctrl_model.cmd(1'b0);
		rchk(stepper_pkg::ADDR_DEVIATION, 32'h0000_0000);
		bwr(stepper_pkg::ADDR_CTRL, 32'h0000_0000);
		chk(en, 1'b1);
		ce <= 1'b0;
		u_host_ctrl_model.cmd(1'b0);
		ce <= 1'b1;
		rchk(stepper_pkg::ADDR_DEVIATION, 32'h0000_0000);
		u_host_ctrl_model.cmd(1'b0);
		chk(done, 1'b0);
		q = {qa, qb};
		u_host_ctrl_model.rotor(10, 1'b1);
		rchk(stepper_pkg::ADDR_POSITION, 32'h0000_000a);
		chk({qa, qb, t_oc}, {~q[0], q[1], 1'b0});
		chk({qa_ld, qb_ld, t_ld}, {~q[0], q[1], 1'b0});
		for (int n = 0; n < ENDC + 50 && done !== 1'b1; n++)
			@(posedge clk_sys);
		chk(done, 1'b1);
		u_host_ctrl_model.cmd(1'b1);
		chk(done, 1'b0);
		u_host_ctrl_model.rotor(10, 1'b0);
		@(posedge clk_sys);
		chk({qa, qb, t_oc}, {q, 1'b1});
		pulse(5'h10);
		chk({led, aok, en}, 3'b100);
		rchk(stepper_pkg::ADDR_STATUS, 32'h0000_0001);
		u_host_ctrl_model.cmd(1'b0);
		rchk(stepper_pkg::ADDR_DEVIATION, 32'h0000_0000);
		pulse(5'h01);
		chk(led, 1'b0);
		for (int i = 0; i < 3; i++) begin
			pulse(5'h08 >> i);
			pulse(5'h01);
			chk(led, 1'b1);
			rst;
		end
		sw <= 1'b1;
		rst;
		q = {qa, qb};
		u_host_ctrl_model.rotor(1, 1'b1);
		@(posedge clk_sys);
		chk({qa, qb}, {~q[0], q[1]});
		report_and_stop;
	end
endmodule : test_stepper_pulse_io
